/* File: rtl/tx_char_encoder_params.svh */
// Constants for the dual-channel transmit character encoder
`ifndef TX_CHAR_ENCODER_PARAMS_SVH
`define TX_CHAR_ENCODER_PARAMS_SVH

// Three-level select codes
`define LVL_LOW 2'h0
`define LVL_MID 2'h1
`define LVL_HIGH 2'h2

// Violation symbol, bit 0 is code bit a
`define SVS_POS 10'h079
`define SVS_NEG 10'h386

// Comma byte and K28 low field
`define COMMA_BYTE 8'hbc
`define K28_LOW 5'h1c

// Characters left in a word-sync run after its first
`define WS_REST 4'hf

// Reset values
`define RD_RESET 1'b0
`define LFSR_SEED 9'h1ff
`define CODE_RESET 10'h000

`endif

/* File: rtl/tx_char_encoder_pkg.sv */
// Types shared by the transmit character encoder
package tx_char_encoder_pkg;

  typedef logic [1:0] level_t;

  typedef enum logic [1:0] {
    KIND_DATA,
    KIND_FILL,
    KIND_SPEC,
    KIND_SYNC
  } char_kind_e;

endpackage : tx_char_encoder_pkg

/* File: rtl/dual_channel_tx_char_encoder.sv */
// Two-channel transmit character selection, 8B/10B encoding and word-sync generation
//
// How it works
// RULE1 - Parity failure emits violation symbol
// RULE2 - Phase buffer error forces violation symbol
// RULE3 - Self-test draws characters from LFSR sequence
// RULE4 - Parity errors shown on channel error flag
// RULE5 - Encoder maps characters to 8B/10B codes
// RULE6 - Two non-overlapping special code tables
// RULE7 - Ten-bit character shifted out LSB first
// RULE8 - Two three-level inputs choose nine modes
// RULE9 - Bypass passes raw; parity failure gives +violation
// RULE10 - Bypass bit mapping a..j from data/control
// RULE11 - Bypass ignores select, channels independent
// RULE12 - Special-select modes decode control and select
// RULE13 - Independent clocks: select follows channel A
// RULE14 - Sync run: sixteen commas, 2nd/3rd reversed
// RULE15 - Atomic run completes, inputs ignored
// RULE16 - Atomic run restarts when start resampled
// RULE17 - Atomic: start checked, rest unchecked parity
// RULE18 - Interruptible run continues on control 00
// RULE19 - Non-00 control ends run, encodes character
// RULE20 - Interruptible parity failure aborts run
// RULE21 - Clock select picks common capture clock
// RULE22 - Odd parity: XOR of covered bits is one
// RULE23 - Parity control chooses covered bits
// RULE24 - Encoded violation follows running disparity
`include "tx_char_encoder_params.svh"

module dual_channel_tx_char_encoder
  import tx_char_encoder_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Configuration
  input wire level_t transmit_operation_select_hi,
  input wire level_t transmit_operation_select_lo,
  input wire level_t parity_check_control,
  input wire level_t input_clock_select,
  // Input clocks from pins
  input wire logic reference_clock,
  input wire logic channel_a_input_clock,
  input wire logic per_channel_input_clock_b,
  // Shared special-character select
  input wire logic special_char_select,
  // Channel A character input
  input wire logic [7:0] char_data_bits_a,
  input wire logic [1:0] char_control_bits_a,
  input wire logic odd_parity_input_a,
  input wire logic phase_buffer_error_a,
  input wire logic bist_active_a,
  // Channel B character input
  input wire logic [7:0] char_data_bits_b,
  input wire logic [1:0] char_control_bits_b,
  input wire logic odd_parity_input_b,
  input wire logic phase_buffer_error_b,
  input wire logic bist_active_b,
  // Channel A output
  output logic [9:0] tx_code_a,
  output logic tx_code_valid_a,
  output logic serial_out_a,
  output logic transmit_error_flag_a,
  // Channel B output
  output logic [9:0] tx_code_b,
  output logic tx_code_valid_b,
  output logic serial_out_b,
  output logic transmit_error_flag_b
);

  // ----------------------------------------
  // Code tables
  // ----------------------------------------
  localparam logic [5:0] TAB6 [32] = '{6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17, 6'h1b, 6'h23, 6'h13, 6'h32, 6'h0b,
    6'h2a, 6'h1a, 6'h3a, 6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
  localparam logic [3:0] TAB4 [8] = '{4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};
  localparam logic [3:0] TAB4_K28 [8] = '{4'h4, 4'h9, 4'h5, 4'h3, 4'h2, 4'ha, 4'h6, 4'h8};
  // Alternate table; several codes land on the comma
  localparam logic [7:0] KALT [16] = '{8'h1c, 8'h3c, 8'h5c, 8'h7c, 8'h9c, 8'hbc, 8'hdc, 8'hfc,
    8'hf7, 8'hfb, 8'hfd, 8'hfe, 8'hbc, 8'hbc, 8'hbc, 8'hbc};

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function automatic logic [9:0] rev10(input logic [9:0] s);
    logic [9:0] r;
    for (int i = 0; i < 10; i++) begin
      r[i] = s[9 - i];
    end
    return r;
  endfunction : rev10

  // Returns {running disparity after, code with bit 0 = a}
  function automatic logic [10:0] enc8b10b(input logic [7:0] b, input logic k, input logic rd);
    logic [5:0] six;
    logic [3:0] four;
    logic rdm;
    logic alt;
    logic [9:0] s;
    logic [3:0] ones;
    six = TAB6[b[4:0]];
    four = TAB4[b[7:5]];
    rdm = rd;
    alt = 1'b0;
    if (k && b[4:0] == `K28_LOW) begin
      s = {6'h0f, TAB4_K28[b[7:5]]};
      if (rd) begin
        s = ~s;
      end
    end else begin
      if (rd && ($countones(six) != 3 || b[4:0] == 5'h07)) begin
        six = ~six;
      end
      rdm = ($countones(six) != 3) ? ~rd : rd;
      alt = b[7:5] == 3'h7 && (k || (!rdm && (b[4:0] == 5'h11 || b[4:0] == 5'h12 || b[4:0] == 5'h14))
        || (rdm && (b[4:0] == 5'h0b || b[4:0] == 5'h0d || b[4:0] == 5'h0e)));
      if (alt) begin
        four = 4'h7;
      end
      if (rdm && ($countones(four) != 2 || b[7:5] == 3'h3)) begin
        four = ~four;
      end
      s = {six, four};
    end
    ones = 4'($countones(s));
    return {(ones == 4'h5) ? rd : (ones > 4'h5), rev10(s)};
  endfunction : enc8b10b

  // Primary table when the byte is a legal special code, alternate otherwise
  function automatic logic [7:0] special_map(input logic [7:0] b);
    if (b[4:0] == `K28_LOW || b == 8'hf7 || b == 8'hfb || b == 8'hfd || b == 8'hfe) begin
      return b;
    end
    return KALT[b[3:0]];
  endfunction : special_map

  function automatic char_kind_e decode(input logic [1:0] c, input logic sc, input level_t lo);
    if (lo == `LVL_LOW) begin
      if (!c[0]) return KIND_DATA;
      if (c[1]) return KIND_SYNC;
      return sc ? KIND_SPEC : KIND_FILL;
    end else if (lo == `LVL_MID) begin
      if (!c[0]) return KIND_DATA;
      if (sc) return KIND_SYNC;
      return c[1] ? KIND_SPEC : KIND_FILL;
    end
    return char_kind_e'(c);
  endfunction : decode

  // ----------------------------------------
  // Input clock synchronisers
  // ----------------------------------------
  logic [2:0] ref_sync_r;
  logic [2:0] cka_sync_r;
  logic [2:0] ckb_sync_r;
  logic ref_edge;
  logic cka_edge;
  logic ckb_edge;
  logic [1:0] strobe;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ref_sync_r <= 3'h0;
      cka_sync_r <= 3'h0;
      ckb_sync_r <= 3'h0;
    end else begin
      ref_sync_r <= {ref_sync_r[1:0], reference_clock};
      cka_sync_r <= {cka_sync_r[1:0], channel_a_input_clock};
      ckb_sync_r <= {ckb_sync_r[1:0], per_channel_input_clock_b};
    end
  end

  assign ref_edge = ref_sync_r[1] & ~ref_sync_r[2];
  assign cka_edge = cka_sync_r[1] & ~cka_sync_r[2];
  assign ckb_edge = ckb_sync_r[1] & ~ckb_sync_r[2];

  // RULE21 common clock choice
  assign strobe[0] = (input_clock_select == `LVL_LOW) ? ref_edge : cka_edge;
  assign strobe[1] = (input_clock_select == `LVL_LOW) ? ref_edge :
                     (input_clock_select == `LVL_HIGH) ? cka_edge : ckb_edge;

  // ----------------------------------------
  // Per-channel input and encode
  // ----------------------------------------
  logic [7:0] d_in [2];
  logic [1:0] c_in [2];
  logic [1:0] p_in;
  logic [1:0] phase_err;
  logic [1:0] bist_on;
  logic [9:0] code_r [2];
  logic [1:0] valid_r;
  logic [9:0] sh_r [2];
  logic [1:0] err_r;
  logic [1:0] evt_r;
  logic sc_cap_r;
  logic sc_b_r;
  logic [1:0] sc_use;

  assign d_in[0] = char_data_bits_a;
  assign d_in[1] = char_data_bits_b;
  assign c_in[0] = char_control_bits_a;
  assign c_in[1] = char_control_bits_b;
  assign p_in = {odd_parity_input_b, odd_parity_input_a};
  assign phase_err = {phase_buffer_error_b, phase_buffer_error_a};
  assign bist_on = {bist_active_b, bist_active_a};

  // RULE13 select sampled on channel A's clock only
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sc_cap_r <= 1'b0;
      sc_b_r <= 1'b0;
    end else begin
      if (strobe[0]) begin
        sc_cap_r <= special_char_select;
      end
      if (evt_r[0]) begin
        sc_b_r <= sc_cap_r;
      end
    end
  end

  assign sc_use[0] = sc_cap_r;
  // Channel A's encode cycle hands its fresh select straight across
  assign sc_use[1] = (input_clock_select == `LVL_MID && !evt_r[0]) ? sc_b_r : sc_cap_r;

  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    logic [7:0] cap_d_r;
    logic [1:0] cap_c_r;
    logic cap_p_r;
    logic rd_r;
    logic [3:0] cnt_r;
    logic [8:0] lfsr_r;
    logic perr_r;
    logic [9:0] code_nxt;
    logic rd_nxt;
    logic [3:0] cnt_nxt;
    logic par_fail;
    logic bypass;
    logic atomic;
    logic [10:0] enc;
    logic [7:0] bist_byte;
    char_kind_e kind;

    always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
        cap_d_r <= 8'h00;
        cap_c_r <= 2'h0;
        cap_p_r <= 1'b0;
        evt_r[ch] <= 1'b0;
      end else begin
        evt_r[ch] <= strobe[ch];
        if (strobe[ch]) begin
          cap_d_r <= d_in[ch];
          cap_c_r <= c_in[ch];
          cap_p_r <= p_in[ch];
        end
      end
    end

    // RULE8 test modes behave as bypass
    assign bypass = transmit_operation_select_hi == `LVL_LOW;
    assign atomic = transmit_operation_select_hi == `LVL_MID;
    assign bist_byte = lfsr_r[7:0];

    always_comb begin
      // RULE22 RULE23 odd parity over selected bits
      par_fail = parity_check_control != `LVL_LOW && !(^{cap_d_r, cap_p_r,
        (parity_check_control == `LVL_HIGH || bypass) ? cap_c_r : 2'h0});
      // RULE12 control and select decoding
      kind = decode(cap_c_r, sc_use[ch], transmit_operation_select_lo);
      code_nxt = `SVS_POS;
      rd_nxt = rd_r;
      cnt_nxt = 4'h0;
      enc = enc8b10b(cap_d_r, 1'b0, rd_r);
      if (bist_on[ch]) begin
        // RULE3 self-test sequence replaces input
        enc = enc8b10b(lfsr_r[8:7] == 2'h3 ? special_map(bist_byte) : bist_byte, lfsr_r[8:7] == 2'h3, rd_r);
        code_nxt = enc[9:0];
        rd_nxt = enc[10];
      end else if (bypass) begin
        // RULE2 RULE9 RULE10 RULE11 raw character or fixed violation
        code_nxt = (par_fail || phase_err[ch]) ? `SVS_POS : {cap_c_r, cap_d_r};
      end else if (phase_err[ch] || (par_fail && !(atomic && cnt_r != 4'h0))) begin
        // RULE1 RULE2 RULE20 RULE24 violation at running disparity
        code_nxt = rd_r ? `SVS_NEG : `SVS_POS;
      end else begin
        // RULE15 RULE17 RULE18 RULE19 run continues or ends
        if (cnt_r != 4'h0 && (atomic || cap_c_r == 2'h0)) begin
          kind = KIND_SYNC;
          cnt_nxt = cnt_r - 4'h1;
        end else if (kind == KIND_SYNC) begin
          // RULE16 fresh start after a finished run
          cnt_nxt = `WS_REST;
        end
        if (kind == KIND_SYNC || kind == KIND_FILL) begin
          // RULE14 second and third commas reversed
          enc = enc8b10b(`COMMA_BYTE, 1'b1,
            rd_r ^ (cnt_nxt == `WS_REST - 4'h1 || cnt_nxt == `WS_REST - 4'h2));
        end else begin
          // RULE5 RULE6 data or special encoding
          enc = enc8b10b(kind == KIND_SPEC ? special_map(cap_d_r) : cap_d_r, kind == KIND_SPEC, rd_r);
        end
        code_nxt = enc[9:0];
        rd_nxt = enc[10];
      end
    end

    always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
        rd_r <= `RD_RESET;
        cnt_r <= 4'h0;
        lfsr_r <= `LFSR_SEED;
        code_r[ch] <= `CODE_RESET;
        valid_r[ch] <= 1'b0;
        perr_r <= 1'b0;
      end else begin
        valid_r[ch] <= evt_r[ch];
        if (evt_r[ch]) begin
          rd_r <= rd_nxt;
          cnt_r <= cnt_nxt;
          code_r[ch] <= code_nxt;
          perr_r <= par_fail && !bist_on[ch] && !(atomic && !bypass && cnt_r != 4'h0);
          if (bist_on[ch]) begin
            lfsr_r <= {lfsr_r[7:0], lfsr_r[8] ^ lfsr_r[4]};
          end else begin
            lfsr_r <= `LFSR_SEED;
          end
        end
      end
    end

    // RULE4 parity or phase fault on error flag
    always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
        err_r[ch] <= 1'b0;
      end else begin
        err_r[ch] <= perr_r | phase_err[ch];
      end
    end

    // RULE7 shifter, bit a leaves first
    always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
        sh_r[ch] <= `CODE_RESET;
      end else if (valid_r[ch]) begin
        sh_r[ch] <= code_r[ch];
      end else begin
        sh_r[ch] <= {1'b0, sh_r[ch][9:1]};
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign tx_code_a = code_r[0];
  assign tx_code_b = code_r[1];
  assign tx_code_valid_a = valid_r[0];
  assign tx_code_valid_b = valid_r[1];
  assign serial_out_a = sh_r[0][0];
  assign serial_out_b = sh_r[1][0];
  assign transmit_error_flag_a = err_r[0];
  assign transmit_error_flag_b = err_r[1];

endmodule : dual_channel_tx_char_encoder

/* File: sim/tx_enc_asserts.sv */
// Port assertions for the transmit character encoder
`include "tx_char_encoder_params.svh"
module tx_enc_asserts
  import tx_char_encoder_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Configuration
  input wire level_t transmit_operation_select_hi,
  input wire level_t parity_check_control,
  input wire level_t input_clock_select,
  input wire logic phase_buffer_error_a,
  // Outputs
  input wire logic [9:0] tx_code_a,
  input wire logic tx_code_valid_a,
  input wire logic serial_out_a,
  input wire logic transmit_error_flag_a,
  input wire logic tx_code_valid_b
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  wire logic bypass = transmit_operation_select_hi == `LVL_LOW;
  wire logic violation_symbol = tx_code_a == `SVS_POS || tx_code_a == `SVS_NEG;

  a_valid_one_cycle: assert property (tx_code_valid_a |=> !tx_code_valid_a)
    else $error("valid held too long");
  a_code_holds: assert property (!tx_code_valid_a |-> $stable(tx_code_a))
    else $error("code moved without valid");
  a_lsb_first: assert property (tx_code_valid_a |=> serial_out_a == tx_code_a[0] ##1
    serial_out_a == tx_code_a[1]) else $error("serial order wrong");
  a_flag_gives_svs: assert property (tx_code_valid_a ##1 transmit_error_flag_a |->
    (bypass ? tx_code_a == `SVS_POS : violation_symbol)) else $error("error without violation");
  a_phase_svs: assert property (phase_buffer_error_a [*8] ##0 tx_code_valid_a |-> violation_symbol)
    else $error("phase error not forced");
  a_phase_flag: assert property (phase_buffer_error_a |=> transmit_error_flag_a)
    else $error("phase error not flagged");
  a_chan_align: assert property (input_clock_select == `LVL_LOW && tx_code_valid_a |-> tx_code_valid_b)
    else $error("channels not aligned");
  a_parity_off_quiet: assert property ((parity_check_control == `LVL_LOW &&
    !phase_buffer_error_a) [*8] |-> !transmit_error_flag_a) else $error("flag with checks off");

  c_comma: cover property (tx_code_valid_a && tx_code_a == 10'h17c);
  c_violation: cover property (tx_code_valid_a && violation_symbol);
  c_bypass: cover property (tx_code_valid_a && bypass);
endmodule : tx_enc_asserts

bind dual_channel_tx_char_encoder tx_enc_asserts u_chk (.mclk, .nrst, .transmit_operation_select_hi,
  .parity_check_control, .input_clock_select, .phase_buffer_error_a, .tx_code_a, .tx_code_valid_a,
  .serial_out_a, .transmit_error_flag_a, .tx_code_valid_b);

/* File: sim/host_char_source.sv */
// Host model presenting one character per reference clock period
module host_char_source (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Next character from the bench
  input wire logic [7:0] nxt_data,
  input wire logic [1:0] nxt_ctl,
  input wire logic nxt_par,
  // Pin side
  output logic reference_clock,
  output logic [7:0] char_data_bits_a,
  output logic [1:0] char_control_bits_a,
  output logic odd_parity_input_a,
  output logic taken
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_r;

  // Sixteen mclk per character keeps the shifter fed
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= 4'h0;
    end else begin
      cnt_r <= cnt_r + 4'h1;
    end
  end

  // Bench supplies control and parity
  // Inputs change eight cycles before the rise, clear of capture
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      reference_clock <= 1'b0;
      char_data_bits_a <= 8'h00;
      char_control_bits_a <= 2'h0;
      odd_parity_input_a <= 1'b0;
      taken <= 1'b0;
    end else begin
      reference_clock <= cnt_r[3];
      taken <= cnt_r == 4'h0;
      if (cnt_r == 4'h0) begin
        char_data_bits_a <= nxt_data;
        char_control_bits_a <= nxt_ctl;
        odd_parity_input_a <= nxt_par;
      end
    end
  end
endmodule : host_char_source

/* File: sim/dual_channel_tx_char_encoder_tb.sv */
// Self-checking bench for the transmit character encoder
`include "tx_char_encoder_params.svh"
module dual_channel_tx_char_encoder_tb
  import tx_char_encoder_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  level_t transmit_operation_select_hi = `LVL_LOW;
  level_t transmit_operation_select_lo = `LVL_LOW;
  level_t parity_check_control = `LVL_LOW;
  level_t input_clock_select = `LVL_LOW;
  logic special_char_select = 1'b0;
  logic phase_buffer_error_a = 1'b0;
  logic bist_active_a = 1'b0;
  logic [7:0] nd = 8'h00;
  logic [1:0] nc = 2'h0;
  logic np = 1'b1;
  logic reference_clock, odd_parity_input_a, taken;
  logic [7:0] char_data_bits_a;
  logic [1:0] char_control_bits_a;
  logic [9:0] tx_code_a, tx_code_b;
  logic tx_code_valid_a, serial_out_a, transmit_error_flag_a;
  logic tx_code_valid_b, serial_out_b, transmit_error_flag_b;
  int errors = 0;
  int checked = 0;

  initial begin
    forever #4 mclk = ~mclk;
  end

  host_char_source u_host (.mclk, .nrst, .nxt_data(nd), .nxt_ctl(nc), .nxt_par(np), .reference_clock,
    .char_data_bits_a, .char_control_bits_a, .odd_parity_input_a, .taken);

  // Both channels share the reference clock and the host's character
  dual_channel_tx_char_encoder DUT (.mclk, .nrst, .transmit_operation_select_hi,
    .transmit_operation_select_lo, .parity_check_control, .input_clock_select, .reference_clock,
    .channel_a_input_clock(reference_clock), .per_channel_input_clock_b(reference_clock), .special_char_select,
    .char_data_bits_a, .char_control_bits_a, .odd_parity_input_a, .phase_buffer_error_a,
    .bist_active_a, .char_data_bits_b(char_data_bits_a), .char_control_bits_b(char_control_bits_a),
    .odd_parity_input_b(odd_parity_input_a), .phase_buffer_error_b(phase_buffer_error_a),
    .bist_active_b(1'b0), .tx_code_a, .tx_code_valid_a, .serial_out_a, .transmit_error_flag_a,
    .tx_code_b, .tx_code_valid_b, .serial_out_b, .transmit_error_flag_b);

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic finish_test();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask : check

  task automatic hang(input logic ok);
    if (!ok) begin
      errors++;
      $display("unexpected at %0t: wait ran out", $time);
      finish_test();
    end
  endtask : hang

  task automatic wait_valid(output logic [9:0] code);
    int n;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (tx_code_valid_a !== 1'b1 && n < 60);
    hang(n < 60);
    code = tx_code_a;
  endtask : wait_valid

  // Waiting for the take keeps repeated characters out of the answer
  task automatic xfer(input logic [7:0] d, input logic [1:0] c, input logic p, output logic [9:0] code);
    int n;
    nd = d;
    nc = c;
    np = p;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (taken !== 1'b1 && n < 40);
    hang(n < 40);
    wait_valid(code);
  endtask : xfer

  task automatic do_reset(input level_t hi, input level_t lo, input level_t pc);
    logic [9:0] junk;
    @(negedge mclk);
    nrst = 1'b0;
    transmit_operation_select_hi = hi;
    transmit_operation_select_lo = lo;
    parity_check_control = pc;
    nd = 8'h00;
    nc = 2'h0;
    np = 1'b1;
    repeat (5) @(negedge mclk);
    nrst = 1'b1;
    wait_valid(junk);
  endtask : do_reset

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_bypass();
    logic [9:0] c;
    logic [9:0] e;
    e = 10'h25a;
    special_char_select = 1'b1;
    do_reset(`LVL_LOW, `LVL_LOW, `LVL_MID);
    xfer(8'h5a, 2'h2, 1'b0, c);
    check(c, e);
    check(tx_code_b, e);
    for (int i = 0; i < 10; i++) begin
      @(negedge mclk);
      check({9'h0, serial_out_a}, {9'h0, e[i]});
      check({9'h0, serial_out_b}, {9'h0, e[i]});
    end
    xfer(8'h5a, 2'h2, 1'b1, c);
    check(c, `SVS_POS);
    @(negedge mclk);
    check({9'h0, transmit_error_flag_a}, 10'h1);
    check({9'h0, transmit_error_flag_b}, 10'h1);
    $display("bypass test done");
  endtask : t_bypass

  task automatic t_encode();
    logic [9:0] c;
    do_reset(`LVL_MID, `LVL_HIGH, `LVL_MID);
    xfer(8'h00, 2'h0, 1'b1, c);
    check(c, 10'h0b9);
    xfer(8'h00, 2'h0, 1'b0, c);
    check(c, `SVS_POS);
    @(negedge mclk);
    check({9'h0, transmit_error_flag_a}, 10'h1);
    phase_buffer_error_a = 1'b1;
    xfer(8'h00, 2'h0, 1'b1, c);
    check(c, `SVS_POS);
    phase_buffer_error_a = 1'b0;
    // Fill comma leaves running disparity positive
    xfer(8'h00, 2'h1, 1'b1, c);
    check(c, 10'h17c);
    xfer(8'h00, 2'h0, 1'b0, c);
    check(c, `SVS_NEG);
    // Sequence starts at the seed, a special comma
    bist_active_a = 1'b1;
    xfer(8'h00, 2'h0, 1'b1, c);
    check(c, 10'h283);
    check(tx_code_b, 10'h346);
    bist_active_a = 1'b0;
    $display("encode test done");
  endtask : t_encode

  task automatic t_atomic();
    logic [9:0] c;
    do_reset(`LVL_MID, `LVL_HIGH, `LVL_LOW);
    // Second start sampled just as the first run ends
    for (int r = 0; r < 2; r++) begin
      xfer(8'hbc, 2'h3, 1'b0, c);
      check(c, 10'h17c);
      // Special requests inside the run must be ignored
      for (int i = 0; i < 15; i++) begin
        xfer(8'h1c, 2'h2, 1'b0, c);
        check(c, (i >= 2 && i % 2 == 0) ? 10'h283 : 10'h17c);
      end
    end
    xfer(8'h00, 2'h0, 1'b0, c);
    check(c, 10'h0b9);
    $display("atomic test done");
  endtask : t_atomic

  task automatic t_interrupt();
    logic [9:0] c;
    input_clock_select = `LVL_HIGH;
    do_reset(`LVL_HIGH, `LVL_HIGH, `LVL_MID);
    xfer(8'hbc, 2'h3, 1'b0, c);
    check(c, 10'h17c);
    xfer(8'h1c, 2'h2, 1'b0, c);
    check(c, 10'h343);
    xfer(8'hbc, 2'h3, 1'b0, c);
    check(c, 10'h283);
    xfer(8'h00, 2'h0, 1'b1, c);
    check(c, 10'h283);
    xfer(8'h00, 2'h0, 1'b0, c);
    check(c, `SVS_POS);
    xfer(8'h00, 2'h0, 1'b1, c);
    check(c, 10'h0b9);
    check(tx_code_b, 10'h0b9);
    $display("interrupt test done");
  endtask : t_interrupt

  task automatic t_select();
    logic [9:0] c;
    input_clock_select = `LVL_MID;
    do_reset(`LVL_MID, `LVL_LOW, `LVL_LOW);
    special_char_select = 1'b0;
    xfer(8'h1c, 2'h1, 1'b0, c);
    check(c, 10'h17c);
    special_char_select = 1'b1;
    xfer(8'h1c, 2'h1, 1'b0, c);
    check(c, 10'h343);
    check(tx_code_b, 10'h343);
    // Alternate table code landing on the comma
    xfer(8'h0d, 2'h1, 1'b0, c);
    check(c, 10'h283);
    xfer(8'h00, 2'h3, 1'b0, c);
    check(c, 10'h17c);
    $display("select test done");
  endtask : t_select

  initial begin
    t_bypass();
    t_encode();
    t_atomic();
    t_interrupt();
    t_select();
    finish_test();
  end
endmodule : dual_channel_tx_char_encoder_tb
